// ==== src/ppwm_core.sv ====
`timescale 1ns/1ps
`include "ppwm_regs.svh"

// What this block does
// - Outside startup, flag clears only from current comparator
// - Comparator gated by drive outputs being on
// - Outputs on only while control input high
// - Flag drops at next pulse rising edge
// - Push-pull; each output at half rate
// - Overcurrent terminates the present switching cycle
// - Overcurrent sets current flag pin high
// - Strap pin selects control mode
// - Overcurrent turns outputs off, raises flag
// - Flag held high until supplies good
// - Pulse input low keeps outputs disabled
// - Each pulse rising edge in the idle state with control input high and no overcurrent starts a period

module ppwm_core (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PULSE_IN,
  input wire logic CTRL_IN,
  input wire logic OVER_LIMIT,
  input wire logic SUPPLY_GOOD,
  input wire ppwm_pkg::ppwm_strap_t MODE_SET_PIN,
  output logic GATE_DRIVE_OUTPUT_A,
  output logic GATE_DRIVE_OUTPUT_B,
  output logic CURRENT_FLAG_PIN,
  output ppwm_pkg::ppwm_mode_t MODE,
  output logic READY
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  ppwm_pkg::ppwm_state_t state_ff;
  ppwm_pkg::ppwm_state_t nxt_state;
  ppwm_pkg::ppwm_drive_t drive_ff;
  ppwm_pkg::ppwm_drive_t nxt_drive;
  logic pulse_d_ff;
  logic phase_ff;
  logic overcurrent_flag_ff;
  logic clear_armed_ff;
  logic [`PPWM_SUPPLY_CNT_W-1:0] supply_cnt_ff;

  // ----------------------------------------
  // Decode nets
  // ----------------------------------------
  logic supply_ok;
  logic pulse_rise;
  logic cut_event;
  logic comp_clear;
  logic take;

  // ----------------------------------------
  // Drive decode
  // ----------------------------------------
  // Shared by the cut and clear paths
  function automatic logic any_on(input ppwm_pkg::ppwm_drive_t d);
    any_on = d.out_a | d.out_b;
  endfunction : any_on

  // One output per period, picked by the phase
  function automatic ppwm_pkg::ppwm_drive_t steer(input logic phase);
    steer.out_a = ~phase;
    steer.out_b = phase;
  endfunction : steer

  assign supply_ok = (supply_cnt_ff == `PPWM_SUPPLY_CNT_W'(`PPWM_SUPPLY_OK_CYC));
  assign pulse_rise = PULSE_IN & ~pulse_d_ff;
  assign cut_event = OVER_LIMIT & any_on(drive_ff);
  // Comparator result counts only while a gate drive is on
  assign comp_clear = ~OVER_LIMIT & any_on(drive_ff);
  // Refused edges leave the steering phase where it was
  assign take = pulse_rise & CTRL_IN & ~OVER_LIMIT;

  ppwm_mode_decode u_mode (
    .CLK(CLK),
    .RSTN(RSTN),
    .capture(supply_ok & ~READY),
    .strap(MODE_SET_PIN),
    .mode_ff(MODE)
  );

  // ----------------------------------------
  // Supply qualification
  // ----------------------------------------
  // Supply must stay good for the whole count; any dropout restarts it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      supply_cnt_ff <= '0;
    end else if (!SUPPLY_GOOD) begin
      supply_cnt_ff <= '0;
    end else if (!supply_ok) begin
      supply_cnt_ff <= supply_cnt_ff + `PPWM_SUPPLY_CNT_W'(1);
    end
  end

  // Mode is caught on the same edge that READY rises
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      READY <= 1'b0;
    end else begin
      READY <= supply_ok;
    end
  end

  // ----------------------------------------
  // Pulse edge detect
  // ----------------------------------------
  // Idles low like the pin, so no false edge follows reset
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pulse_d_ff <= 1'b0;
    end else begin
      pulse_d_ff <= PULSE_IN;
    end
  end

  // ----------------------------------------
  // Period sequencer
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_drive = '0;
    case (state_ff)
      ppwm_pkg::PPWM_ST_STARTUP: begin
        if (READY) begin
          nxt_state = ppwm_pkg::PPWM_ST_IDLE;
        end
      end
      ppwm_pkg::PPWM_ST_IDLE: begin
        if (take) begin
          nxt_state = ppwm_pkg::PPWM_ST_ON;
          nxt_drive = steer(phase_ff);
        end
      end
      ppwm_pkg::PPWM_ST_ON: begin
        // Overcurrent is tested first, so a cut beats a normal end
        if (cut_event) begin
          nxt_state = ppwm_pkg::PPWM_ST_CUT;
        end else if (!PULSE_IN || !CTRL_IN) begin
          nxt_state = ppwm_pkg::PPWM_ST_IDLE;
        end else begin
          nxt_drive = drive_ff;
        end
      end
      ppwm_pkg::PPWM_ST_CUT: begin
        // Truncated pulse stays off until the pulse input falls
        if (!PULSE_IN) begin
          nxt_state = ppwm_pkg::PPWM_ST_IDLE;
        end
      end
      default: begin
        // Unreachable code; recover with outputs off
        nxt_state = ppwm_pkg::PPWM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= ppwm_pkg::PPWM_ST_STARTUP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      drive_ff <= '0;
    end else begin
      drive_ff <= nxt_drive;
    end
  end

  // Phase flips per started period, so each output runs at half rate
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      phase_ff <= 1'b0;
    end else if (state_ff == ppwm_pkg::PPWM_ST_IDLE && take) begin
      phase_ff <= ~phase_ff;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign GATE_DRIVE_OUTPUT_A = drive_ff.out_a;
  assign GATE_DRIVE_OUTPUT_B = drive_ff.out_b;

  // ----------------------------------------
  // Overcurrent flag
  // ----------------------------------------
  // Arm remembers that a clear condition was seen; the drop waits for a pulse edge
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      clear_armed_ff <= 1'b0;
    end else if (cut_event || !overcurrent_flag_ff) begin
      clear_armed_ff <= 1'b0;
    end else if (comp_clear) begin
      clear_armed_ff <= 1'b1;
    end
  end

  // A cut in the same cycle as a clear wins
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      overcurrent_flag_ff <= 1'b1;
    end else if (state_ff == ppwm_pkg::PPWM_ST_STARTUP) begin
      overcurrent_flag_ff <= ~READY;
    end else if (cut_event) begin
      overcurrent_flag_ff <= 1'b1;
    end else if (pulse_rise && (clear_armed_ff || comp_clear)) begin
      overcurrent_flag_ff <= 1'b0;
    end
  end

  assign CURRENT_FLAG_PIN = overcurrent_flag_ff;

endmodule : ppwm_core

// ==== src/ppwm_regs.svh ====
`ifndef PPWM_REGS_SVH
`define PPWM_REGS_SVH

// ----------------------------------------
// Mode strap encodings
// ----------------------------------------
`define PPWM_MODE_W 2
`define PPWM_STRAP_VOLTAGE 2'h0
`define PPWM_STRAP_FEEDFWD 2'h1
`define PPWM_STRAP_PEAK 2'h2

// ----------------------------------------
// Supply qualification
// ----------------------------------------
`define PPWM_SUPPLY_OK_NS 1000
`define PPWM_CLK_NS 8
`define PPWM_SUPPLY_OK_CYC ((`PPWM_SUPPLY_OK_NS + `PPWM_CLK_NS - 1) / `PPWM_CLK_NS)
`define PPWM_SUPPLY_CNT_W 8

`endif

// ==== src/ppwm_pkg.sv ====
package ppwm_pkg;

  typedef enum logic [1:0] {
    PPWM_MODE_VOLTAGE,
    PPWM_MODE_FEEDFWD,
    PPWM_MODE_PEAK,
    PPWM_MODE_NONE
  } ppwm_mode_t;

  typedef enum logic [1:0] {
    PPWM_ST_STARTUP,
    PPWM_ST_IDLE,
    PPWM_ST_ON,
    PPWM_ST_CUT
  } ppwm_state_t;

  typedef struct packed {
    logic to_regulator;
    logic to_vin;
    logic to_ground;
  } ppwm_strap_t;

  typedef struct packed {
    logic out_a;
    logic out_b;
  } ppwm_drive_t;

endpackage : ppwm_pkg

// ==== src/ppwm_mode_decode.sv ====
`timescale 1ns/1ps
`include "ppwm_regs.svh"

module ppwm_mode_decode (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic capture,
  input wire ppwm_pkg::ppwm_strap_t strap,
  output ppwm_pkg::ppwm_mode_t mode_ff
);

  // ----------------------------------------
  // Strap decode
  // ----------------------------------------
  function automatic ppwm_pkg::ppwm_mode_t decode_strap(input ppwm_pkg::ppwm_strap_t s);
    if (s.to_ground) begin
      decode_strap = ppwm_pkg::PPWM_MODE_PEAK;
    end else if (s.to_vin) begin
      decode_strap = ppwm_pkg::PPWM_MODE_FEEDFWD;
    end else if (s.to_regulator) begin
      decode_strap = ppwm_pkg::PPWM_MODE_VOLTAGE;
    end else begin
      decode_strap = ppwm_pkg::PPWM_MODE_NONE;
    end
  endfunction : decode_strap

  // Caught by a clock edge after reset release, never by the reset itself
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_ff <= ppwm_pkg::PPWM_MODE_NONE;
    end else if (capture) begin
      mode_ff <= decode_strap(strap);
    end
  end

endmodule : ppwm_mode_decode

// ==== verif/ppwm_core_sva.sv ====
`timescale 1ns/1ps
// ----
// Checks
// ----
module ppwm_core_sva (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PULSE_IN,
  input wire logic CTRL_IN,
  input wire logic OVER_LIMIT,
  input wire logic GATE_DRIVE_OUTPUT_A,
  input wire logic GATE_DRIVE_OUTPUT_B,
  input wire logic CURRENT_FLAG_PIN,
  input wire logic READY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic on_w;
  logic seen_ff;
  logic last_b_ff;
  assign on_w = GATE_DRIVE_OUTPUT_A | GATE_DRIVE_OUTPUT_B;
  // Armed once an output ran clean after the flag rose; a new cut disarms
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) seen_ff <= 1'b0;
    else seen_ff <= CURRENT_FLAG_PIN & ~(on_w & OVER_LIMIT) & (seen_ff | on_w & ~OVER_LIMIT);
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) last_b_ff <= 1'b1;
    else if (on_w) last_b_ff <= GATE_DRIVE_OUTPUT_B;
  end
  sequence s_take;
    !PULSE_IN ##1 PULSE_IN && CTRL_IN && !OVER_LIMIT && READY;
  endsequence
  sequence s_arm;
    !PULSE_IN && READY ##1 PULSE_IN && seen_ff;
  endsequence
  chk_never_both: assert property (!(GATE_DRIVE_OUTPUT_A && GATE_DRIVE_OUTPUT_B)) else $error("both on");
  chk_drive_gated: assert property (!PULSE_IN || !CTRL_IN || OVER_LIMIT |=> !on_w) else $error("not off");
  chk_over_flag: assert property (on_w && OVER_LIMIT |=> CURRENT_FLAG_PIN) else $error("no flag");
  chk_flag_clear: assert property (s_arm |=> !CURRENT_FLAG_PIN) else $error("no clear");
  chk_flag_cause: assert property (READY && $past(READY) && CURRENT_FLAG_PIN && !seen_ff && (!on_w || OVER_LIMIT)
    |=> CURRENT_FLAG_PIN) else $error("bad clear");
  chk_start_flag: assert property (!READY |-> CURRENT_FLAG_PIN) else $error("early low");
  chk_period_start: assert property (s_take |=> on_w) else $error("no start");
  chk_alt_order: assert property ($rose(GATE_DRIVE_OUTPUT_A) |-> last_b_ff) else $error("order");
endmodule : ppwm_core_sva
bind ppwm_core ppwm_core_sva chk (.CLK, .RSTN, .PULSE_IN, .CTRL_IN, .OVER_LIMIT, .GATE_DRIVE_OUTPUT_A,
  .GATE_DRIVE_OUTPUT_B, .CURRENT_FLAG_PIN, .READY);

// ==== verif/ppwm_host.sv ====
`timescale 1ns/1ps
// ----
// Host pulse train
// ----
module ppwm_host (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic flag,
  input wire logic en,
  input wire logic [3:0] hi,
  output logic pulse
);
  logic [3:0] cnt_ff;
  logic ok_ff;
  always_ff @(negedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_ff <= 4'h0;
      ok_ff <= 1'b0;
      pulse <= 1'b0;
    end else begin
      ok_ff <= ok_ff | ~flag;
      cnt_ff <= cnt_ff + 4'h1;
      pulse <= en & ok_ff & (cnt_ff < hi);
    end
  end
endmodule : ppwm_host

// ==== verif/ppwm_core_bench.sv ====
`timescale 1ns/1ps
// ----
// Bench
// ----
module ppwm_core_bench;
  logic clk, rstn, pulse, ctrl, over, sup, en, ga, gb, flag, rdy, tog, pq, won;
  logic [3:0] hi;
  logic [1:0] expq[$];
  ppwm_pkg::ppwm_strap_t strap;
  ppwm_pkg::ppwm_mode_t mode;
  int miscompares, check_count;
  integer seed;
  ppwm_core uut (.CLK(clk), .RSTN(rstn), .PULSE_IN(pulse), .CTRL_IN(ctrl), .OVER_LIMIT(over),
    .SUPPLY_GOOD(sup), .MODE_SET_PIN(strap), .GATE_DRIVE_OUTPUT_A(ga), .GATE_DRIVE_OUTPUT_B(gb),
    .CURRENT_FLAG_PIN(flag), .MODE(mode), .READY(rdy));
  ppwm_host host (.CLK(clk), .RSTN(rstn), .flag(flag), .en(en), .hi(hi), .pulse(pulse));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %h %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic wait_until(input logic want_on);
    int i;
    for (i = 0; i < 400 && (want_on ? (ga | gb) !== 1'b1 : flag !== 1'b0); i++) @(negedge clk);
    if (i == 400) begin
      miscompares++;
      complete_run;
    end
  endtask : wait_until
  // Refused edges do not advance the A/B order
  always @(posedge clk) begin
    if (pulse && !pq && ctrl && !over && rdy) begin
      expq.push_back(tog ? 2'h2 : 2'h1);
      tog = !tog;
    end
    pq = pulse;
  end
  always @(negedge clk) begin
    if ((ga | gb) && !won) check({ga, gb}, expq.size() > 0 ? expq.pop_front() : 2'h3);
    won = ga | gb;
  end
  initial begin
    seed = 32'he8692fe0;
    {en, over, sup, rstn, pq, won} = 6'h0;
    {ctrl, tog} = 2'h3;
    hi = 4'h8;
    strap = 3'h1;
    for (int m = 0; m < 3; m++) begin
      rstn = 1'b0;
      sup = 1'b0;
      strap = ppwm_pkg::ppwm_strap_t'(3'h1 << m);
      expq.delete();
      tog = 1'b1;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      repeat (40) @(negedge clk);
      check({rdy, flag}, 2'h1);
      sup = 1'b1;
      wait_until(1'b0);
      check({rdy, flag}, 2'h2);
      check(mode, 2'(2 - m));
    end
    en <= 1'b1;
    repeat (40) begin
      ctrl = ($random(seed) & 7) != 0;
      hi <= 4'h2 + 4'($random(seed) & 7);
      repeat (4'($random(seed) & 7)) @(negedge clk);
      over = ($random(seed) & 3) == 0;
      @(negedge clk);
      over = 1'b0;
      repeat (9) @(negedge clk);
    end
    ctrl = 1'b1;
    hi <= 4'h8;
    wait_until(1'b1);
    over = 1'b1;
    @(negedge clk);
    over = 1'b0;
    check({1'b0, flag}, 2'h1);
    check({ga, gb}, 2'h0);
    repeat (48) @(negedge clk);
    check({1'b0, flag}, 2'h0);
    check(2'(expq.size()), 2'h0);
    complete_run;
  end
endmodule : ppwm_core_bench
